// ==== src/pwr_mode_pkg.sv ====
// Package for the power-save mode controller: register map, fields, states.
// Assumes a classic Wishbone slave with 32-bit data and byte addressing.
package pwr_mode_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] deep_sleep_control_addr = 8'h00;
  localparam logic [7:0] wake_source_flags_addr = 8'h04;
  localparam logic [7:0] reset_control_addr = 8'h08;
  localparam logic [7:0] interrupt_vector_status_addr = 8'h0c;
  localparam logic [7:0] power_config_addr = 8'h10;
  localparam logic [7:0] power_status_addr = 8'h14;

  // ==========================================================
  // Field positions
  localparam int arm_bit = 15;
  localparam int release_bit = 0;
  localparam int brownout_flag_bit = 1;
  localparam int deep_sleep_status_bit = 10;
  localparam int pending_irq_bit = 15;
  // Wake source flag positions
  localparam int wk_por = 0;
  localparam int wk_master_clear_pin = 1;
  localparam int wk_alarm = 2;
  localparam int wk_ext = 3;
  localparam int wk_deep_sleep_watchdog = 4;
  localparam int wk_width = 5;
  // Configuration register fields
  localparam int cfg_wdt_en = 0;
  localparam int cfg_cal_en = 1;
  localparam int cfg_cal_on_low_power_rc_clock = 2;
  localparam int cfg_cfm_en = 3;
  localparam int cfg_regulator_en = 4;
  localparam int cfg_alarm_wake_en = 5;
  localparam int cfg_ext_wake_en = 6;
  localparam int cfg_deep_sleep_watchdog_en = 7;
  localparam int cfg_width = 8;

  // ==========================================================
  // Timing: arm window in instruction cycles
  localparam logic [1:0] arm_window_cycles = 2'h3;
  // Cycles from wake until the power-on sequence is taken as complete
  localparam logic [3:0] por_settle_cycles = 4'h8;

  localparam logic [31:0] unmapped_read = 32'h0000_0000;

  // ==========================================================
  // Power-save instruction operands
  localparam logic operand_sleep = 1'b0;
  localparam logic operand_idle = 1'b1;

  typedef enum logic [2:0] {
    st_run = 3'b000,
    st_sleep = 3'b001,
    st_idle = 3'b010,
    st_deep = 3'b011,
    st_por = 3'b100
  } mode_e;

  // Wake event inputs grouped together
  typedef struct packed {
    logic irq;           // Any individually enabled interrupt
    logic dev_reset;     // Any device reset request
    logic wdt_timeout;
    logic por;
    logic master_clear_pin;
    logic alarm;
    logic ext;
    logic deep_sleep_watchdog_timeout;
    logic deep_sleep_brownout;
  } wake_s;

  // Gating outputs grouped together
  typedef struct packed {
    logic cpu_clk_en;
    logic sys_osc_en;
    logic periph_clk_en;
    logic low_power_rc_clock_en;
    logic io_freeze;
    logic core_supply_en;
    logic wdt_clear;
    logic deep_sleep_watchdog_clear;
  } gate_s;

endpackage

// ==== src/power_save_mode_control.sv ====
// Power-save mode controller: Sleep, Idle and Deep Sleep entry, gating and wake.
// Assumes the CPU pulses pwrsav_i once per power-save instruction and that
// instr_tick_i marks each instruction cycle; registers sit on classic Wishbone.
//
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
module power_save_mode_control (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // CPU side
  input wire logic instr_tick_i,
  input wire logic pwrsav_i,
  input wire logic pwrsav_operand_i,
  input wire logic pending_irq_i,
  input wire logic [2:0] osc_select_i,
  output logic pwrsav_skip_o,
  output logic resume_o,
  output logic [2:0] resume_osc_o,
  // Wake sources and gates
  input wire pwr_mode_pkg::wake_s wake_i,
  output pwr_mode_pkg::gate_s gate_o,
  output pwr_mode_pkg::mode_e mode_o
);

  // ==========================================================
  // State
  typedef struct packed {
    pwr_mode_pkg::mode_e mode;
    logic arm;
    logic [1:0] arm_cnt;
    logic release_io;
    logic brownout_flag;
    logic status;
    logic [pwr_mode_pkg::wk_width-1:0] wake;
    logic [pwr_mode_pkg::cfg_width-1:0] cfg;
    logic irq_held;
    logic [2:0] saved_osc;
    logic [3:0] por_cnt;
    logic resume;
    logic skip;
    logic wdt_clear;
    logic deep_sleep_watchdog_clear;
    logic ack;
    logic [31:0] rdata;
  } state_s;

  state_s r;
  state_s next_r;

  function automatic logic [31:0] read_mux(input state_s s, input logic [7:0] a);
    logic [31:0] d;
    d = pwr_mode_pkg::unmapped_read;
    if (a == pwr_mode_pkg::deep_sleep_control_addr) begin
      d[pwr_mode_pkg::arm_bit] = s.arm;
      d[pwr_mode_pkg::brownout_flag_bit] = s.brownout_flag;
      d[pwr_mode_pkg::release_bit] = s.release_io;
    end else if (a == pwr_mode_pkg::wake_source_flags_addr) begin
      d[pwr_mode_pkg::wk_width-1:0] = s.wake;
    end else if (a == pwr_mode_pkg::reset_control_addr) begin
      d[pwr_mode_pkg::deep_sleep_status_bit] = s.status;
    end else if (a == pwr_mode_pkg::interrupt_vector_status_addr) begin
      d[pwr_mode_pkg::pending_irq_bit] = pending_irq_i;
    end else if (a == pwr_mode_pkg::power_config_addr) begin
      d[pwr_mode_pkg::cfg_width-1:0] = s.cfg;
    end else if (a == pwr_mode_pkg::power_status_addr) begin
      d[2:0] = s.mode;
    end
    return d;
  endfunction

  logic bus_req;
  logic wr;
  logic wr_ctl;
  logic wr_rst;
  logic wr_cfg;
  logic [pwr_mode_pkg::wk_width-1:0] ds_events;
  logic ds_wake;
  logic sleep_wake;

  assign bus_req = cyc_i && stb_i && !r.ack;
  assign wr = bus_req && we_i;
  assign wr_ctl = wr && adr_i == pwr_mode_pkg::deep_sleep_control_addr;
  assign wr_rst = wr && adr_i == pwr_mode_pkg::reset_control_addr;
  assign wr_cfg = wr && adr_i == pwr_mode_pkg::power_config_addr && sel_i[0];

  // Deep Sleep wake events, alarm, external and deep sleep watchdog only while enabled in the configuration register
  always_comb begin
    ds_events = '0;
    ds_events[pwr_mode_pkg::wk_por] = wake_i.por;
    ds_events[pwr_mode_pkg::wk_master_clear_pin] = wake_i.master_clear_pin;
    ds_events[pwr_mode_pkg::wk_alarm] = wake_i.alarm && r.cfg[pwr_mode_pkg::cfg_alarm_wake_en];
    ds_events[pwr_mode_pkg::wk_ext] = wake_i.ext && r.cfg[pwr_mode_pkg::cfg_ext_wake_en];
    ds_events[pwr_mode_pkg::wk_deep_sleep_watchdog] = wake_i.deep_sleep_watchdog_timeout
                                        && r.cfg[pwr_mode_pkg::cfg_deep_sleep_watchdog_en];
  end
  assign ds_wake = |ds_events;
  assign sleep_wake = wake_i.irq || wake_i.dev_reset || wake_i.wdt_timeout
                      || r.irq_held;

  // ==========================================================
  // Next state
  always_comb begin
    next_r = r;
    next_r.resume = 1'b0;
    next_r.skip = 1'b0;
    next_r.wdt_clear = 1'b0;
    next_r.deep_sleep_watchdog_clear = 1'b0;
    next_r.ack = bus_req;
    next_r.rdata = bus_req ? read_mux(r, adr_i) : r.rdata;

    // Register writes
    if (wr_ctl && sel_i[1]) begin
      next_r.arm = dat_i[pwr_mode_pkg::arm_bit];
      next_r.arm_cnt = '0;
      if (dat_i[pwr_mode_pkg::arm_bit]) begin
        next_r.wake = '0;
      end
    end
    if (wr_ctl && sel_i[0] && !dat_i[pwr_mode_pkg::release_bit]) begin
      next_r.release_io = 1'b0;
    end
    if (wr_ctl && sel_i[0] && !dat_i[pwr_mode_pkg::brownout_flag_bit]) begin
      next_r.brownout_flag = 1'b0;
    end
    if (wr_rst && sel_i[1] && !dat_i[pwr_mode_pkg::deep_sleep_status_bit]) begin
      next_r.status = 1'b0;
    end
    if (wr_cfg) begin
      next_r.cfg = dat_i[pwr_mode_pkg::cfg_width-1:0];
    end

    // Arm window counted in instruction cycles, only before entry: once in
    // Deep Sleep the arm bit must stay set until the exit clears it
    if (r.mode == pwr_mode_pkg::st_run && r.arm && instr_tick_i && !(wr_ctl && sel_i[1])) begin
      if (r.arm_cnt == pwr_mode_pkg::arm_window_cycles) begin
        next_r.arm = 1'b0;
      end else begin
        next_r.arm_cnt = r.arm_cnt + 2'h1;
      end
    end

    case (r.mode)
      pwr_mode_pkg::st_run: begin
        if (pwrsav_i) begin
          if (r.arm && pwrsav_operand_i == pwr_mode_pkg::operand_sleep) begin
            if (pending_irq_i || !r.cfg[pwr_mode_pkg::cfg_regulator_en]) begin
              next_r.skip = 1'b1;
              next_r.arm = 1'b0;
            end else begin
              next_r.mode = pwr_mode_pkg::st_deep;
              next_r.arm = 1'b1;
              next_r.status = 1'b1;
              next_r.release_io = 1'b1;
              next_r.deep_sleep_watchdog_clear = 1'b1;
            end
          end else if (pwrsav_operand_i == pwr_mode_pkg::operand_sleep) begin
            next_r.mode = pwr_mode_pkg::st_sleep;
            next_r.saved_osc = osc_select_i;
            next_r.wdt_clear = r.cfg[pwr_mode_pkg::cfg_wdt_en];
            next_r.irq_held = wake_i.irq;
          end else begin
            next_r.mode = pwr_mode_pkg::st_idle;
            next_r.wdt_clear = r.cfg[pwr_mode_pkg::cfg_wdt_en];
            next_r.irq_held = wake_i.irq;
          end
        end
      end
      pwr_mode_pkg::st_sleep, pwr_mode_pkg::st_idle: begin
        next_r.irq_held = 1'b0;
        if (sleep_wake) begin
          next_r.mode = pwr_mode_pkg::st_run;
          next_r.resume = 1'b1;
        end
      end
      pwr_mode_pkg::st_deep: begin
        if (wake_i.deep_sleep_brownout) begin
          next_r.brownout_flag = 1'b1;
          next_r.release_io = 1'b0;
        end
        if (ds_wake) begin
          next_r.wake = r.wake | ds_events;
          next_r.arm = 1'b0;
          next_r.mode = pwr_mode_pkg::st_por;
          next_r.por_cnt = '0;
          if (wake_i.por) begin
            next_r.release_io = 1'b0;
          end
        end
      end
      pwr_mode_pkg::st_por: begin
        // Wake events here are not recorded
        if (r.por_cnt == pwr_mode_pkg::por_settle_cycles) begin
          next_r.mode = pwr_mode_pkg::st_run;
          next_r.resume = 1'b1;
        end else begin
          next_r.por_cnt = r.por_cnt + 4'h1;
        end
      end
      default: begin
        next_r.mode = pwr_mode_pkg::st_run;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs
  logic in_sleep;
  logic in_deep;
  assign in_sleep = r.mode == pwr_mode_pkg::st_sleep;
  assign in_deep = r.mode == pwr_mode_pkg::st_deep || r.mode == pwr_mode_pkg::st_por;

  always_comb begin
    gate_o.cpu_clk_en = r.mode == pwr_mode_pkg::st_run;
    gate_o.sys_osc_en = !in_sleep && !in_deep;
    gate_o.periph_clk_en = !in_sleep && !in_deep;
    if (in_sleep) begin
      gate_o.low_power_rc_clock_en = r.cfg[pwr_mode_pkg::cfg_wdt_en]
                       || (r.cfg[pwr_mode_pkg::cfg_cal_en]
                           && r.cfg[pwr_mode_pkg::cfg_cal_on_low_power_rc_clock]);
    end else if (r.mode == pwr_mode_pkg::st_idle) begin
      gate_o.low_power_rc_clock_en = r.cfg[pwr_mode_pkg::cfg_wdt_en]
                       || r.cfg[pwr_mode_pkg::cfg_cfm_en];
    end else begin
      gate_o.low_power_rc_clock_en = 1'b1;
    end
    gate_o.io_freeze = in_sleep || r.release_io;
    gate_o.core_supply_en = !in_deep;
    gate_o.wdt_clear = r.wdt_clear;
    gate_o.deep_sleep_watchdog_clear = r.deep_sleep_watchdog_clear;
  end

  assign mode_o = r.mode;
  assign resume_o = r.resume;
  assign resume_osc_o = r.saved_osc;
  assign pwrsav_skip_o = r.skip;
  assign dat_o = r.rdata;
  assign ack_o = r.ack;

endmodule

// ==== sim/pwr_mode_checker.sv ====
// Port assertions for the power-save mode controller.
// Assumes a master that releases its request at the ack edge.
`timescale 1ns/10ps
module pwr_mode_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [2:0] osc_select_i,
  input wire logic pwrsav_skip_o,
  input wire logic [2:0] resume_osc_o,
  input wire pwr_mode_pkg::wake_s wake_i,
  input wire pwr_mode_pkg::gate_s gate_o,
  input wire pwr_mode_pkg::mode_e mode_o
);
  logic run, slp, idl, dp, por;
  assign run = mode_o == pwr_mode_pkg::st_run;
  assign slp = mode_o == pwr_mode_pkg::st_sleep;
  assign idl = mode_o == pwr_mode_pkg::st_idle;
  assign dp = mode_o == pwr_mode_pkg::st_deep;
  assign por = mode_o == pwr_mode_pkg::st_por;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ======
  // Assertions
  AST_BUS_ACK: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack is not a single pulse after the request");
  AST_SLEEP_GATE: assert property (slp |-> gate_o[7:5] == 3'h0 && gate_o.io_freeze)
    else $error("sleep left a clock running or pins loose");
  AST_IDLE_GATE: assert property (idl |-> gate_o[7:5] == 3'h3)
    else $error("idle gating wrong");
  AST_DEEP_GATE: assert property (dp |-> gate_o[7:5] == 3'h0 && gate_o[3:2] == 2'h2)
    else $error("deep sleep gating wrong");
  AST_WAKE: assert property ((slp || idl) && (wake_i.irq || wake_i.wdt_timeout) |=> run)
    else $error("no wake from sleep or idle");
  AST_RESUME_OSC: assert property (slp && $past(run) |-> resume_osc_o == $past(osc_select_i))
    else $error("oscillator not captured at sleep entry");
  AST_DEEP_WAKE: assert property (dp && (wake_i.por || wake_i.master_clear_pin) |=> por)
    else $error("no exit from deep sleep");
  AST_POR_SETTLE: assert property ($rose(por) |-> por [*8] ##1 por ##1 run)
    else $error("power-on settle length wrong");
  AST_SKIP: assert property (pwrsav_skip_o |-> run ##1 run)
    else $error("skipped instruction changed the mode");
  // ======
  // Coverage
  cover property (dp);
  cover property (pwrsav_skip_o);
  cover property ($rose(por));
endmodule

bind power_save_mode_control pwr_mode_checker chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .osc_select_i(osc_select_i), .pwrsav_skip_o(pwrsav_skip_o),
  .resume_osc_o(resume_osc_o), .wake_i(wake_i), .gate_o(gate_o), .mode_o(mode_o));

// ==== sim/fw_model.sv ====
// CPU model: issues one power-save instruction a set gap after a go request.
// Assumes one instruction cycle per clock.
`timescale 1ns/10ps
module fw_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench requests
  input wire logic go_i,
  input wire logic op_i,
  input wire logic [1:0] gap_i,
  // Instruction stream
  output logic pwrsav_o,
  output logic operand_o
);
  logic [1:0] cnt;
  logic busy, op_q;
  always_ff @(posedge clk_i) begin
    pwrsav_o <= 1'b0;
    // Operand is only meaningful with the pulse, so it wanders while the model is idle
    operand_o <= ~operand_o;
    if (rst_i) begin
      busy <= 1'b0;
      operand_o <= 1'b0;
    end else if (go_i) begin
      cnt <= gap_i;
      op_q <= op_i;
      busy <= gap_i != 2'h0;
      pwrsav_o <= gap_i == 2'h0;
      operand_o <= op_i;
    end else if (busy) begin
      cnt <= cnt - 2'h1;
      busy <= cnt != 2'h1;
      pwrsav_o <= cnt == 2'h1;
      operand_o <= op_q;
    end
  end
endmodule

// ==== sim/power_save_mode_control_tb.sv ====
// Self-checking bench for the power-save mode controller.
// Assumes the CPU model in fw_model.sv and the checker bound by itself.
`timescale 1ns/10ps
module power_save_mode_control_tb;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc_i = 0, stb_i = 0, we_i = 0, tick = 1, pend = 0, go = 0, op = 0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic ack_o, skip, res, pws, opnd;
  logic [1:0] gap = 2'h0;
  logic [2:0] osc = 3'h5, res_osc;
  pwr_mode_pkg::wake_s wake = '0;
  pwr_mode_pkg::gate_s gate;
  pwr_mode_pkg::mode_e mode;
  int err_count = 0, n_tests = 0, n_skip = 0, n_wclr = 0, n_res = 0, k = 0, n_dclr = 0;

  power_save_mode_control dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .instr_tick_i(tick), .pwrsav_i(pws), .pwrsav_operand_i(opnd),
    .pending_irq_i(pend), .osc_select_i(osc), .pwrsav_skip_o(skip), .resume_o(res),
    .resume_osc_o(res_osc), .wake_i(wake), .gate_o(gate), .mode_o(mode));
  fw_model cpu (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .op_i(op), .gap_i(gap),
    .pwrsav_o(pws), .operand_o(opnd));

  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // Pulses are counted here; read the counts only at a falling edge
  always @(posedge clk_i) begin
    if (skip) n_skip++;
    if (gate.wdt_clear) n_wclr++;
    if (res) n_res++;
    if (gate.deep_sleep_watchdog_clear) n_dclr++;
  end

  // ======
  // Shared tasks
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic limit;
    err_count++;
    $display("wait limit reached at %0t", $time);
    wrap_up;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    for (i = 0; i < 20 && ack_o !== 1'b1; i++) @(posedge clk_i);
    if (ack_o !== 1'b1) limit;
    rd = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask
  task automatic wait_mode(input pwr_mode_pkg::mode_e m);
    int i;
    for (i = 0; i < 40 && mode !== m; i++) @(posedge clk_i);
    if (mode !== m) limit;
  endtask
  task automatic fire(input logic o, input logic [1:0] g);
    {go, op, gap} <= {1'b1, o, g};
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  task automatic pause;
    repeat (2) @(negedge clk_i);
  endtask
  task automatic wake_by(input logic [8:0] w);
    k = n_res;
    @(posedge clk_i);
    wake <= w;
    wait_mode(pwr_mode_pkg::st_run);
    wake <= '0;
    pause;
    check(n_res - k, 1);
  endtask

  // ======
  // Scenarios
  task automatic t_regs;
    wb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, 8'h10, 32'h1ff);
    wb(1'b0, 8'h10, 32'h0);
    check(rd, 32'hff);
    wb(1'b1, 8'h20, 32'hffff);
    wb(1'b0, 8'h20, 32'h0);
    check(rd, pwr_mode_pkg::unmapped_read);
    $display("test regs done");
  endtask
  task automatic t_sleep;
    wb(1'b1, 8'h10, 32'h03);
    k = n_wclr;
    fire(1'b0, 2'h0);
    wait_mode(pwr_mode_pkg::st_sleep);
    check(32'(gate[7:3]), 32'h03);
    osc <= 3'h2;
    pause;
    check(n_wclr - k, 1);
    wake_by(9'h100);
    check(32'(res_osc), 32'h5);
    k = n_wclr;
    fire(1'b1, 2'h0);
    wait_mode(pwr_mode_pkg::st_idle);
    pause;
    check(32'(gate[7:4]), 32'h7);
    check(n_wclr - k, 1);
    wake_by(9'h040);
    fire(1'b1, 2'h0);
    wait_mode(pwr_mode_pkg::st_idle);
    wake_by(9'h080);
    // Interrupt only at the instruction edge: the held copy must do the wake
    fire(1'b0, 2'h0);
    wake <= 9'h100;
    @(posedge clk_i);
    wake <= '0;
    wait_mode(pwr_mode_pkg::st_sleep);
    wake_by(9'h000);
    $display("test sleep and idle done");
  endtask
  task automatic t_skip;
    int i;
    for (i = 0; i < 2; i++) begin
      @(posedge clk_i);
      pend <= i == 0;
      wb(1'b1, 8'h10, i ? 32'h01 : 32'h11);
      wb(1'b0, 8'h0c, 32'h0);
      check(rd, i ? 32'h0 : 32'h8000);
      wb(1'b1, 8'h00, 32'h8000);
      k = n_skip;
      fire(1'b0, 2'h0);
      repeat (4) @(negedge clk_i);
      check(n_skip - k, 1);
      check(32'(mode), 32'h0);
    end
    @(posedge clk_i);
    pend <= 1'b0;
    wb(1'b1, 8'h10, 32'h51);
    wb(1'b1, 8'h00, 32'h8000);
    fire(1'b0, 2'h3);
    wait_mode(pwr_mode_pkg::st_sleep);
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    wake_by(9'h100);
    $display("test skip and window done");
  endtask
  task automatic t_deep;
    wb(1'b1, 8'h00, 32'h8000);
    k = n_dclr;
    fire(1'b0, 2'h0);
    wait_mode(pwr_mode_pkg::st_deep);
    check(32'({gate[7:5], gate[3:2]}), 32'h02);
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h8001);
    wake <= 9'h010;
    wait_mode(pwr_mode_pkg::st_por);
    wake <= 9'h004;
    wait_mode(pwr_mode_pkg::st_run);
    wake <= '0;
    wb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h2);
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h1);
    check(32'(gate.io_freeze), 32'h1);
    wb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h400);
    check(n_dclr - k, 1);
    wb(1'b1, 8'h00, 32'h0);
    pause;
    check(32'(gate.io_freeze), 32'h0);
    wb(1'b1, 8'h00, 32'h8000);
    wb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0);
    $display("test deep sleep done");
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_sleep;
    t_skip;
    t_deep;
    wrap_up;
  end
endmodule
